// ### rcrb_defines.svh
// Register offsets, field positions and reset values of the regulator config bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef RCRB_DEFINES_SVH
`define RCRB_DEFINES_SVH

`define RCRB_OFS_SLOPE      8'h20
`define RCRB_OFS_ZERO3      8'h21
`define RCRB_OFS_MISC       8'h22
`define RCRB_OFS_SOFT_RESET_CMD       8'h23
`define RCRB_OFS_SHORT      8'h30
`define RCRB_OFS_BBOPT      8'h31
`define RCRB_OFS_COMP_CH1_CH2      8'h32
`define RCRB_OFS_COMP_CH3       8'h33
`define RCRB_OFS_COMP_CH4       8'h34

`define RCRB_SOFT_RESET_CMD_KEY       8'h55

`define RCRB_RST_SLOPE      8'h04
`define RCRB_RST_ZERO3      8'h40
`define RCRB_RST_MISC       8'h07
`define RCRB_RST_SOFT_RESET_CMD       8'h00
`define RCRB_RST_BBOPT      8'h02
`define RCRB_RST_COMP_CH1_CH2      8'h00
`define RCRB_RST_COMP_CH3       8'h00
`define RCRB_RST_COMP_CH4       8'h00

`define RCRB_MASK_SLOPE     8'hff
`define RCRB_MASK_ZERO3     8'h70
`define RCRB_MASK_MISC      8'h7f
`define RCRB_MASK_BBOPT     8'h0f
`define RCRB_MASK_COMP_CH1_CH2     8'hff
`define RCRB_MASK_COMP_CH3      8'h0f
`define RCRB_MASK_COMP_CH4      8'hf0

`define RCRB_BIT_FORCE      6
`define RCRB_BIT_PGPP       3
`define RCRB_BIT_EXTILIM    4
`define RCRB_BIT_PULSE_SKIP_CH1       1
`define RCRB_BIT_STEP_DOWN_ONLY_EN     0

`endif

// ### rcrb_pkg.sv
// Types shared by the regulator config bank files.
// Assumes rcrb_defines.svh on the include path.
`include "rcrb_defines.svh"
package rcrb_pkg;
	typedef enum logic [1:0] {
		RCRB_IDLE = 2'b00,
		RCRB_SHUT = 2'b01
	} rcrb_state_type;
endpackage

// ### rcrb_reg8.sv
// One 8-bit configuration register with load value, write mask and reload.
// Assumes synchronous active-low reset and a single clock.
`timescale 1ns/1ps
`default_nettype none
module rcrb_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK    = 8'hff
) (
	input  wire logic       i_clk,    // System clock
	input  wire logic       i_rst_b,  // Sync reset, low
	input  wire logic       i_reload, // Return to default
	input  wire logic       i_we,     // Write strobe
	input  wire logic [7:0] i_wdata,  // Write data
	output logic      [7:0] o_q       // Register value
);
	logic [7:0] q_reg;
	logic [7:0] q_next;

	// Undefined bits hold zero regardless of writes
	assign q_next = (!i_rst_b || i_reload) ? (RST_VAL & MASK) :
	                i_we ? (i_wdata & MASK) : q_reg;

	always_ff @(posedge i_clk) begin
		q_reg <= q_next;
	end

	assign o_q = q_reg;
endmodule // rcrb_reg8
`default_nettype wire

// ### rcrb_bank.sv
// Regulator configuration and status register bank, offsets 0x20 to 0x34.
// Assumes a config-port front end that gives a one-cycle write strobe and
// reads combinationally; hard-short events arrive synchronous to i_clk.
// Notes on behaviour
// - Writing 0x55 to the soft-reset register starts a soft reset; register resets zero.
// - Soft reset reloads all defaults and shuts the chip regardless of enable pin.
// - Hard-short flags read-only, reset zero; bit 2n-1 negative, 2n-2 positive.
// - Channel 4 slope bits 7:6: 4.7, 2.2, 10, 6.8 uH; default 00.
// - Channel 3 ramp bits 5:4: supply over 14, 7, 28, 17.5; default 00.
// - Channel 2 slope bits 3:2 default 01, channel 1 bits 1:0 default 00.
// - Channel 3 filter zero bits 6:5 select LC pole band; default 10.
// - Bit 4 selects external switch limit: 0 is 200 mV, 1 is 100 mV.
// - Control bit 6 forces load switch one on, disabling its current limit.
// - With force set, load switch follows its enable bit and soft-reset shutdown, ignoring enable pin.
// - Control bit 3 selects power-good output: 0 open drain, 1 push-pull.
// - Control bits 2..0 enable pulse skipping channels 4,3,2; default 1.
// - Transition threshold bits 3:2 select 80, 85, 70, 75 percent.
// - Options bit 1 channel 1 pulse skipping default 1; bit 0 step-down only.
// - Pole selectors: code 00 is 0.35 Hz base, others two, four, eight times.
// - Channel 1, 2, 4 gain codes map to 20, 26, 32, 38 dB.
// - Channel 3 compensation: pole bits 3:2, gain bits 1:0 at 5..13 dB.
// - Channel 4 compensation: pole bits 7:6, gain bits 5:4; default 00.
`timescale 1ns/1ps
`include "rcrb_defines.svh"
`default_nettype none
module rcrb_bank
	import rcrb_pkg::*;
#(
	parameter int SHUT_CYCLES = 4
) (
	input  wire logic       i_clk,                  // 200 MHz clock
	input  wire logic       i_rst_b,                // Sync reset, low
	input  wire logic       i_wr,                   // Register write strobe
	input  wire logic [7:0] i_addr,                 // Register offset
	input  wire logic [7:0] i_wdata,                // Write data
	output logic      [7:0] o_rdata,                // Read data
	input  wire logic [7:0] i_short_evt,            // Hard-short events
	input  wire logic       i_global_en,            // Global enable pin
	input  wire logic       i_switch_enable_reg,    // Load switch enable bit
	output logic            o_chip_shutdown,        // Soft-reset shutdown
	output logic            o_load_switch_one,      // Load switch on
	output logic            o_load_switch_one_ilim, // Switch limit active
	output logic      [1:0] o_ch4_slope_sel,        // Ch4 slope
	output logic      [1:0] o_ch3_ramp_sel,         // Ch3 ramp
	output logic      [1:0] o_ch2_slope_sel,        // Ch2 slope
	output logic      [1:0] o_ch1_slope_sel,        // Ch1 slope
	output logic      [1:0] o_ch3_filter_zero_sel,  // Ch3 zero band
	output logic            o_ext_switch_ilim_sel,  // 1 is 100 mV
	output logic      [1:0] o_aux_regulator_voltage_sel, // Aux LDO volts
	output logic            o_power_good_pushpull_sel,   // PG type
	output logic      [3:0] o_pulse_skip,           // Ch4..ch1 skip enable
	output logic      [1:0] o_transition_threshold_sel,  // BB threshold
	output logic            o_step_down_only_en,    // Buck only
	output logic      [1:0] o_pole_sel [4],         // Pole per channel
	output logic      [1:0] o_gain_sel [4]          // Gain per channel
);
	localparam int NREG = 8;

	// Counter is eight bits wide
	if (SHUT_CYCLES < 1 || SHUT_CYCLES > 255) begin : g_bad_shut
		$error("SHUT_CYCLES out of range");
	end

	function automatic logic [7:0] ofs_of(input int idx);
		case (idx)
			0: ofs_of = `RCRB_OFS_SLOPE;
			1: ofs_of = `RCRB_OFS_ZERO3;
			2: ofs_of = `RCRB_OFS_MISC;
			3: ofs_of = `RCRB_OFS_SOFT_RESET_CMD;
			4: ofs_of = `RCRB_OFS_BBOPT;
			5: ofs_of = `RCRB_OFS_COMP_CH1_CH2;
			6: ofs_of = `RCRB_OFS_COMP_CH3;
			default: ofs_of = `RCRB_OFS_COMP_CH4;
		endcase
	endfunction

	localparam logic [7:0] RST_TAB [NREG] = '{`RCRB_RST_SLOPE, `RCRB_RST_ZERO3,
		`RCRB_RST_MISC, `RCRB_RST_SOFT_RESET_CMD, `RCRB_RST_BBOPT, `RCRB_RST_COMP_CH1_CH2,
		`RCRB_RST_COMP_CH3, `RCRB_RST_COMP_CH4};
	localparam logic [7:0] MASK_TAB [NREG] = '{`RCRB_MASK_SLOPE, `RCRB_MASK_ZERO3,
		`RCRB_MASK_MISC, 8'hff, `RCRB_MASK_BBOPT, `RCRB_MASK_COMP_CH1_CH2,
		`RCRB_MASK_COMP_CH3, `RCRB_MASK_COMP_CH4};

	logic [7:0]     q [NREG];
	logic [NREG-1:0] we;
	logic           soft_rst;
	logic [7:0]     short_reg;
	logic [7:0]     short_next;
	logic [7:0]     cnt_reg;
	logic [7:0]     cnt_next;
	rcrb_state_type state_reg;
	rcrb_state_type state_next;

	// Key write triggers reload of every register next edge
	assign soft_rst = i_wr && (i_addr == `RCRB_OFS_SOFT_RESET_CMD) &&
	                  (i_wdata == `RCRB_SOFT_RESET_CMD_KEY);

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			assign we[g] = i_wr && (i_addr == ofs_of(g)) && !soft_rst;
			rcrb_reg8 #(
				.RST_VAL (RST_TAB[g]),
				.MASK    (MASK_TAB[g])
			) u_reg (
				.i_clk    (i_clk),
				.i_rst_b  (i_rst_b),
				.i_reload (soft_rst),
				.i_we     (we[g]),
				.i_wdata  (i_wdata),
				.o_q      (q[g])
			);
		end
	endgenerate

	// Flags are sticky; cleared only by reset or soft reset
	assign short_next = (!i_rst_b || soft_rst) ? 8'h00 :
	                    (short_reg | i_short_evt);

	always_ff @(posedge i_clk) begin
		short_reg <= short_next;
	end

	// Shutdown hold after soft reset
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			RCRB_IDLE: begin
				if (soft_rst) begin
					state_next = RCRB_SHUT;
					cnt_next   = 8'(SHUT_CYCLES - 1);
				end
			end
			RCRB_SHUT: begin
				if (cnt_reg == 8'h00) begin
					state_next = RCRB_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: begin
				state_next = RCRB_IDLE;
			end
		endcase
		if (!i_rst_b) begin
			state_next = RCRB_IDLE;
			cnt_next   = 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		state_reg <= state_next;
		cnt_reg   <= cnt_next;
	end

	assign o_chip_shutdown = (state_reg == RCRB_SHUT);

	// Read mux
	always_comb begin
		o_rdata = 8'h00;
		if (i_addr == `RCRB_OFS_SHORT) begin
			o_rdata = short_reg;
		end
		for (int k = 0; k < NREG; k++) begin
			if (i_addr == ofs_of(k)) begin
				o_rdata = q[k];
			end
		end
	end

	// Field taps
	assign o_ch4_slope_sel       = q[0][7:6];
	assign o_ch3_ramp_sel        = q[0][5:4];
	assign o_ch2_slope_sel       = q[0][3:2];
	assign o_ch1_slope_sel       = q[0][1:0];
	assign o_ch3_filter_zero_sel = q[1][6:5];
	assign o_ext_switch_ilim_sel = q[1][`RCRB_BIT_EXTILIM];
	assign o_aux_regulator_voltage_sel = q[2][5:4];
	assign o_power_good_pushpull_sel   = q[2][`RCRB_BIT_PGPP];
	assign o_pulse_skip = {q[2][2:0], q[4][`RCRB_BIT_PULSE_SKIP_CH1]};
	assign o_transition_threshold_sel  = q[4][3:2];
	assign o_step_down_only_en = q[4][`RCRB_BIT_STEP_DOWN_ONLY_EN];
	assign o_pole_sel[0] = q[5][3:2];
	assign o_gain_sel[0] = q[5][1:0];
	assign o_pole_sel[1] = q[5][7:6];
	assign o_gain_sel[1] = q[5][5:4];
	assign o_pole_sel[2] = q[6][3:2];
	assign o_gain_sel[2] = q[6][1:0];
	assign o_pole_sel[3] = q[7][7:6];
	assign o_gain_sel[3] = q[7][5:4];

	// Load switch one gating
	assign o_load_switch_one_ilim = !q[2][`RCRB_BIT_FORCE];
	assign o_load_switch_one = !o_chip_shutdown && i_switch_enable_reg &&
		(q[2][`RCRB_BIT_FORCE] || i_global_en);

	key_write_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> (q[0] == `RCRB_RST_SLOPE) && (q[2] == `RCRB_RST_MISC)
		&& (q[3] == 8'h00))
		else $error("soft reset did not reload defaults");

	shutdown_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> o_chip_shutdown && !o_load_switch_one)
		else $error("shutdown not entered");

	short_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_short_evt != 8'h00) && !soft_rst |=>
		((short_reg & $past(i_short_evt)) == $past(i_short_evt)))
		else $error("short flag lost");

	slope_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[0] |=> (o_ch4_slope_sel == $past(i_wdata[7:6]))
		&& (o_ch2_slope_sel == $past(i_wdata[3:2])))
		else $error("slope write not applied");

	zero_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[1] |=> (q[1] == ($past(i_wdata) & 8'h70)))
		else $error("undefined bits not zero");

	force_switch_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		q[2][6] && i_switch_enable_reg && !o_chip_shutdown
		|-> o_load_switch_one && !o_load_switch_one_ilim)
		else $error("forced switch not on");

	misc_fields_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[2] |=> (o_pulse_skip[3:1] == $past(i_wdata[2:0]))
		&& (o_power_good_pushpull_sel == $past(i_wdata[3])))
		else $error("control fields wrong");

	comp_ch4_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[7] |=> (o_pole_sel[3] == $past(i_wdata[7:6]))
		&& (q[7][3:0] == 4'h0))
		else $error("ch4 compensation wrong");

	soft_reset_cmd_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_wr && (i_addr == `RCRB_OFS_SOFT_RESET_CMD) && (i_wdata != `RCRB_SOFT_RESET_CMD_KEY)
		|=> (q[3] == $past(i_wdata)))
		else $error("soft reset register not stored");

	short_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> (short_reg == 8'h00))
		else $error("short flags not cleared");

	shut_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> (cnt_reg == 8'(SHUT_CYCLES - 1)))
		else $error("shutdown count not loaded");

	shut_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_chip_shutdown && (cnt_reg == 8'h00) && !soft_rst |=> !o_chip_shutdown)
		else $error("shutdown did not end");

	shut_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_chip_shutdown && !soft_rst |=> !o_chip_shutdown)
		else $error("spurious shutdown");

	shut_switch_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_chip_shutdown |-> !o_load_switch_one)
		else $error("switch on during shutdown");

	reload_rest_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> (q[1] == `RCRB_RST_ZERO3) && (q[4] == `RCRB_RST_BBOPT)
		&& (q[5] == 8'h00) && (q[6] == 8'h00) && (q[7] == 8'h00))
		else $error("soft reset left a register set");

	skip_default_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |=> (o_pulse_skip == 4'hf))
		else $error("pulse skip default wrong");

	short_ro_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_wr && (i_addr == `RCRB_OFS_SHORT) && !soft_rst && (i_short_evt == 8'h00)
		|=> (short_reg == $past(short_reg)))
		else $error("short flags written");

	short_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_addr == `RCRB_OFS_SHORT) |-> (o_rdata == short_reg))
		else $error("short flags misread");

	reset_value_a: assert property (@(posedge i_clk)
		!i_rst_b |=> (q[2] == `RCRB_RST_MISC) && (short_reg == 8'h00)
		&& (q[0] == `RCRB_RST_SLOPE) && !o_chip_shutdown)
		else $error("reset values wrong");

	unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_addr < 8'h20) || (i_addr > 8'h34) || ((i_addr > 8'h23) && (i_addr < 8'h30))
		|-> (o_rdata == 8'h00))
		else $error("unmapped offset not zero");

	reg_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_wr && !soft_rst |=> (q[0] == $past(q[0])) && (q[2] == $past(q[2])))
		else $error("register changed without write");

	ramp_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[0] |=> (o_ch3_ramp_sel == $past(i_wdata[5:4]))
		&& (o_ch1_slope_sel == $past(i_wdata[1:0])))
		else $error("ramp or ch1 slope wrong");

	zero_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[1] |=> (o_ch3_filter_zero_sel == $past(i_wdata[6:5]))
		&& (o_ext_switch_ilim_sel == $past(i_wdata[4])))
		else $error("zero band or limit wrong");

	ilim_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[2] |=> (o_load_switch_one_ilim == !$past(i_wdata[6])))
		else $error("switch limit wrong");

	switch_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!q[2][6] && !i_global_en |-> !o_load_switch_one)
		else $error("switch on without enable pin");

	misc_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[2] |=> (q[2][7] == 1'b0)
		&& (o_aux_regulator_voltage_sel == $past(i_wdata[5:4])))
		else $error("control register bits wrong");

	bbopt_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[4] |=> (o_transition_threshold_sel == $past(i_wdata[3:2]))
		&& (o_pulse_skip[0] == $past(i_wdata[1]))
		&& (o_step_down_only_en == $past(i_wdata[0])))
		else $error("options fields wrong");

	bbopt_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[4] |=> (q[4][7:4] == 4'h0))
		else $error("options upper bits not zero");

	comp_ch1_ch2_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[5] |=> (o_pole_sel[0] == $past(i_wdata[3:2]))
		&& (o_gain_sel[0] == $past(i_wdata[1:0]))
		&& (o_pole_sel[1] == $past(i_wdata[7:6]))
		&& (o_gain_sel[1] == $past(i_wdata[5:4])))
		else $error("ch1 ch2 compensation wrong");

	comp_ch3_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[6] |=> (o_pole_sel[2] == $past(i_wdata[3:2]))
		&& (o_gain_sel[2] == $past(i_wdata[1:0])) && (q[6][7:4] == 4'h0))
		else $error("ch3 compensation wrong");

	comp_ch4_gain_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		we[7] |=> (o_gain_sel[3] == $past(i_wdata[5:4])))
		else $error("ch4 gain wrong");

	key_blocks_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_rst |-> (we == '0))
		else $error("write strobe during soft reset");
endmodule // rcrb_bank
`default_nettype wire

// ### rcrb_host.sv
// Host model on the config port: issues register writes and reads.
// Assumes the bench calls its tasks and drives nothing of this bus itself.
`timescale 1ns/1ps
`default_nettype none
module rcrb_host (
	input  wire logic       i_clk,   // Bus clock
	input  wire logic [7:0] i_rdata, // Read data
	output logic            o_wr,    // Write strobe
	output logic      [7:0] o_addr,  // Register offset
	output logic      [7:0] o_wdata  // Write data
);
	initial begin
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// Strobe stays high so writes may run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(posedge i_clk);
	endtask
	// Released data never keeps its last value
	task automatic rel();
		@(negedge i_clk);
		o_wr = 1'b0;
		o_wdata = ~o_wdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = a;
		@(posedge i_clk);
		d = i_rdata;
	endtask
endmodule // rcrb_host
`default_nettype wire

// ### rcrb_bank_tb.sv
// Bench for the regulator config bank: defaults, access, fields, shorts, soft reset.
// Assumes rcrb_host drives the config port; the bench drives the other pins.
`timescale 1ns/1ps
`default_nettype none
module rcrb_bank_tb;
	import rcrb_pkg::*;
	localparam int SHUT = 4;
	logic       clk, rst_b, wr, glob_en, sw_en, shutdown, ls_one, ls_ilim;
	logic       ext_ilim, pp_sel, bk_only;
	logic [7:0] addr, wdata, rdata, short_evt;
	logic [1:0] s4, r3, s2, s1, zero3, aux, thr;
	logic [3:0] psk;
	logic [1:0] pole [4];
	logic [1:0] gain [4];
	logic [7:0] ofs [10] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h24};
	logic [7:0] dft [10] = '{8'h04, 8'h40, 8'h07, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk [10] = '{8'hff, 8'h70, 8'h7f, 8'hff, 8'h00, 8'h0f, 8'hff, 8'h0f, 8'hf0, 8'h00};
	int         num_errors = 0;
	int         num_checks = 0;

	rcrb_host u_rcrb_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_addr(addr),
		.o_wdata(wdata));
	rcrb_bank #(.SHUT_CYCLES(SHUT)) u_rcrb_bank (.i_clk(clk), .i_rst_b(rst_b), .i_wr(wr),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_short_evt(short_evt),
		.i_global_en(glob_en), .i_switch_enable_reg(sw_en), .o_chip_shutdown(shutdown),
		.o_load_switch_one(ls_one), .o_load_switch_one_ilim(ls_ilim), .o_ch4_slope_sel(s4),
		.o_ch3_ramp_sel(r3), .o_ch2_slope_sel(s2), .o_ch1_slope_sel(s1),
		.o_ch3_filter_zero_sel(zero3), .o_ext_switch_ilim_sel(ext_ilim),
		.o_aux_regulator_voltage_sel(aux), .o_power_good_pushpull_sel(pp_sel),
		.o_pulse_skip(psk), .o_transition_threshold_sel(thr), .o_step_down_only_en(bk_only),
		.o_pole_sel(pole), .o_gain_sel(gain));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_rcrb_host.rd(a, d);
		check(d, exp);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_defaults();
		for (int i = 0; i < 10; i++)
			rchk(ofs[i], dft[i]);
	endtask
	task automatic t_masks();
		logic [7:0] p;
		for (int k = 0; k < 2; k++) begin
			p = k ? 8'h00 : 8'hff;
			for (int i = 0; i < 10; i++) begin
				u_rcrb_host.wr(ofs[i], p);
				u_rcrb_host.rel();
				rchk(ofs[i], p & msk[i]);
			end
		end
	endtask
	task automatic t_fields();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			u_rcrb_host.wr(8'h20, {c, ~c, c, ~c});
			u_rcrb_host.wr(8'h21, {1'b0, c, 5'h00});
			u_rcrb_host.wr(8'h22, {2'b00, c, 4'h0});
			u_rcrb_host.wr(8'h31, {4'h0, c, 2'b00});
			u_rcrb_host.wr(8'h32, {c, ~c, ~c, c});
			u_rcrb_host.wr(8'h33, {4'h0, c, ~c});
			u_rcrb_host.wr(8'h34, {c, ~c, 4'h0});
			u_rcrb_host.rel();
			check({s4, r3, s2, s1}, {c, ~c, c, ~c});
			check({zero3, aux, thr, 2'b00}, {c, c, c, 2'b00});
			check({pole[1], gain[1], pole[0], gain[0]}, {c, ~c, ~c, c});
			check({pole[2], gain[2], pole[3], gain[3]}, {c, ~c, c, ~c});
		end
	endtask
	task automatic t_bits();
		logic b;
		for (int i = 0; i < 2; i++) begin
			b = i[0];
			u_rcrb_host.wr(8'h21, {3'b000, b, 4'h0});
			u_rcrb_host.wr(8'h22, {1'b0, b, 2'b00, b, {3{~b}}});
			u_rcrb_host.wr(8'h31, {6'h00, b, b});
			u_rcrb_host.rel();
			check({ext_ilim, ls_ilim, pp_sel, psk, bk_only}, {b, ~b, b, ~b, ~b, ~b, b, b});
		end
	endtask
	task automatic t_switch();
		logic f, g, e;
		for (int i = 0; i < 8; i++) begin
			{f, g, e} = i[2:0];
			u_rcrb_host.wr(8'h22, {1'b0, f, 6'h07});
			u_rcrb_host.rel();
			glob_en = g;
			sw_en = e;
			#1;
			check(8'(ls_one), 8'(e & (f | g)));
		end
	endtask
	task automatic t_shorts();
		@(negedge clk) short_evt = 8'h81;
		@(negedge clk) short_evt = 8'h00;
		rchk(8'h30, 8'h81);
		u_rcrb_host.wr(8'h30, 8'h00);
		u_rcrb_host.rel();
		@(negedge clk) short_evt = 8'h24;
		@(negedge clk) short_evt = 8'h00;
		rchk(8'h30, 8'ha5);
	endtask
	task automatic t_soft_reset_cmd();
		int n;
		n = 0;
		u_rcrb_host.wr(8'h20, 8'hff);
		u_rcrb_host.wr(8'h23, 8'h55);
		u_rcrb_host.rel();
		check(8'(ls_one), 8'h00);
		while (shutdown === 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		check(8'(n), 8'(SHUT));
		t_defaults();
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
	initial begin
		rst_b = 1'b0;
		glob_en = 1'b0;
		sw_en = 1'b0;
		short_evt = 8'h00;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		t_defaults();
		t_masks();
		t_fields();
		t_bits();
		t_switch();
		t_shorts();
		t_soft_reset_cmd();
		wrap_up();
	end
endmodule // rcrb_bank_tb
`default_nettype wire
